// ==== rtl/dct_regs.vh ====
/*
 * Object indices, sub-indices, reset values and converter figures of the
 * drive calibration and test-signal objects.
 * Assumes inclusion by the block that owns the object dictionary slice.
 */
// Summary of operation
// - Nonzero calibration trigger starts offset adjustment
// - Phase offsets are 32 times converter counts
// - Master may write phase offsets directly
// - Reference offset signed, scaled by 32, applied
// - Analogue target read-only, -1023 to +1023
// - Motor currents read-only signed 16-bit
// - Small variant: bus flag 1 above 30V
// - Large variant: bus voltage 16-bit read-only
// - Current test: duration 25, amplitudes 100
// - Motion test: duration, velocity, ramp slope defaults
// - Signed move length limits test travel
// - Selection 6: velocity means path length
// - Writing 1 to start launches test
// - Test selection decoded 0 to 10
`ifndef DCT_REGS_VH
`define DCT_REGS_VH
// Object indices
`define DCT_IDX_CALIB 16'h2064
`define DCT_IDX_CURRENT 16'h2070
`define DCT_IDX_TARGET 16'h2071
`define DCT_IDX_BUSV 16'h2072
`define DCT_IDX_CTEST 16'h2090
`define DCT_IDX_MTEST 16'h2091
`define DCT_IDX_TEST 16'h20a0
// Sub-indices
`define DCT_SUB_0 8'h00
`define DCT_SUB_1 8'h01
`define DCT_SUB_2 8'h02
`define DCT_SUB_3 8'h03
`define DCT_SUB_4 8'h04
`define DCT_SUB_5 8'h05
`define DCT_SUB_6 8'h06
`define DCT_SUB_7 8'h07
`define DCT_SUB_8 8'h08
// Entry counts
`define DCT_CALIB_ENTRIES 32'h00000003
`define DCT_CURRENT_ENTRIES 32'h00000002
`define DCT_BUSV_ENTRIES 32'h00000002
`define DCT_CTEST_ENTRIES 32'h00000003
`define DCT_MTEST_ENTRIES 32'h00000004
`define DCT_TEST_ENTRIES 32'h00000002
// Reset values of the writable entries
`define DCT_RST_CTEST_DUR 8'h19
`define DCT_RST_CTEST_AMP 16'h0064
`define DCT_RST_MTEST_DUR 16'h01f4
`define DCT_RST_MTEST_VEL 32'h00002710
`define DCT_RST_MTEST_ACC 32'h000f4240
`define DCT_RST_MTEST_LEN 32'h0000c350
// Converter and calibration figures
`define DCT_CAL_SAMPLES 6'h20
`define DCT_TARGET_MAX 16'sh03ff
`define DCT_TARGET_MIN -16'sh03ff
`define DCT_BUS_30V_CODE 16'h001e
// Test selections
`define DCT_SEL_NORMAL 8'h00
`define DCT_SEL_MAX_VEL 8'h06
`define DCT_SEL_LAST 8'h0a
`define DCT_LAUNCH_CODE 8'h01
// Test progress codes
`define DCT_TST_IDLE 8'h00
`define DCT_TST_RUN 8'h01
`define DCT_TST_DONE 8'h02
`endif

// ==== rtl/dct_top.v ====
/*
 * Calibration, observation and test-signal objects of a servo drive.
 * A service-data engine presents one object access at a time on the
 * od_* port; converter samples, currents and bus voltage come from the
 * drive core as synchronous inputs, and the test generator in the core
 * follows the mode and parameters driven out here.
 */
`timescale 1ns/1ps
`include "dct_regs.vh"

module dct_top #(
    parameter LARGE_VARIANT = 0
) (
    input wire clk,
    input wire rst_n,
    input wire [15:0] od_index,
    input wire [7:0] od_sub,
    input wire od_wr,
    input wire od_rd,
    input wire [31:0] od_wdata,
    output reg [31:0] od_rdata,
    output reg od_ack,
    output reg od_err,
    input wire adc_valid,
    input wire [10:0] adc_u,
    input wire [10:0] adc_v,
    input wire [10:0] adc_w,
    input wire [10:0] adc_ref,
    input wire [15:0] cur_q,
    input wire [15:0] cur_d,
    input wire [15:0] cur_u,
    input wire [15:0] cur_v,
    input wire [15:0] cur_w,
    input wire [15:0] bus_voltage,
    input wire test_done,
    output reg calib_busy,
    output reg [15:0] phase_v_offset,
    output reg [15:0] phase_w_offset,
    output reg [15:0] target_value,
    output reg test_active,
    output reg [3:0] test_mode,
    output reg [7:0] ctest_duration,
    output reg [15:0] ctest_amp_q,
    output reg [15:0] ctest_amp_d,
    output reg [15:0] mtest_duration,
    output reg [31:0] mtest_velocity,
    output reg [31:0] mtest_accel,
    output reg [31:0] mtest_path_limit
);

    localparam ST_IDLE = 1'b0;
    localparam ST_ACC = 1'b1;
    // Stored entries
    reg [15:0] ref_offset, dead_band, mon_u, mon_v, mon_w;
    reg [31:0] travel_limit, vel_entry;
    reg [7:0] test_sel, test_status;
    reg [15:0] iq_val, id_val, iu_val, iv_val, iw_val, busv_val;
    reg busv_flag;
    // Calibration engine
    reg cal_state;
    reg [5:0] cal_count;
    reg [15:0] acc_u, acc_v, acc_w;
    // Access decode
    reg [31:0] next_rdata;
    reg next_err, ro_hit, rw_hit;
    wire [23:0] key;
    wire wr_ok;
    wire cal_go;
    wire launch;
    wire [16:0] ref_diff;
    wire [15:0] ref_scaled;
    wire [15:0] ref_clamped;

    // Sign-extend an 11-bit converter sample to 16 bits
    function [15:0] sx11;
        input [10:0] a;
        begin
            sx11 = {{5{a[10]}}, a};
        end
    endfunction

    // Sign-extend 16 to 32 bits for signed entries on reads
    function [31:0] sx16;
        input [15:0] a;
        begin
            sx16 = {{16{a[15]}}, a};
        end
    endfunction

    // Clamp a 12-bit signed value to the target range
    function [15:0] clamp;
        input [11:0] a;
        begin
            clamp = {{4{a[11]}}, a};
            if ($signed(clamp) > $signed(`DCT_TARGET_MAX))
                clamp = `DCT_TARGET_MAX;
            if ($signed(clamp) < $signed(`DCT_TARGET_MIN))
                clamp = `DCT_TARGET_MIN;
        end
    endfunction
    // Map a test selection to the mode code driven to the core
    function [3:0] sel_mode;
        input [7:0] s;
        begin
            sel_mode = (s > `DCT_SEL_LAST) ? 4'h0 : s[3:0];
        end
    endfunction

    assign key = {od_index, od_sub};
    // Decode the access: read data, and whether the entry is writable
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        ro_hit = 1'b0;
        rw_hit = 1'b0;
        // Read data; write-only entries leave it zero, unmapped ones abort
        case (key)
            {`DCT_IDX_CALIB, `DCT_SUB_0}: next_rdata = `DCT_CALIB_ENTRIES;
            {`DCT_IDX_CALIB, `DCT_SUB_1}, {`DCT_IDX_TEST, `DCT_SUB_2}: ;
            {`DCT_IDX_CALIB, `DCT_SUB_2}: next_rdata = sx16(phase_v_offset);
            {`DCT_IDX_CALIB, `DCT_SUB_3}: next_rdata = sx16(phase_w_offset);
            {`DCT_IDX_CALIB, `DCT_SUB_4}: next_rdata = sx16(ref_offset);
            {`DCT_IDX_CALIB, `DCT_SUB_5}: next_rdata = sx16(dead_band);
            {`DCT_IDX_CALIB, `DCT_SUB_6}: next_rdata = sx16(mon_u);
            {`DCT_IDX_CALIB, `DCT_SUB_7}: next_rdata = sx16(mon_v);
            {`DCT_IDX_CALIB, `DCT_SUB_8}: next_rdata = sx16(mon_w);
            {`DCT_IDX_CURRENT, `DCT_SUB_0}: next_rdata = `DCT_CURRENT_ENTRIES;
            {`DCT_IDX_CURRENT, `DCT_SUB_1}: next_rdata = sx16(iq_val);
            {`DCT_IDX_CURRENT, `DCT_SUB_2}: next_rdata = sx16(id_val);
            {`DCT_IDX_CURRENT, `DCT_SUB_3}: next_rdata = sx16(iu_val);
            {`DCT_IDX_CURRENT, `DCT_SUB_4}: next_rdata = sx16(iv_val);
            {`DCT_IDX_CURRENT, `DCT_SUB_5}: next_rdata = sx16(iw_val);
            {`DCT_IDX_TARGET, `DCT_SUB_0}: next_rdata = sx16(target_value);
            {`DCT_IDX_BUSV, `DCT_SUB_0}: next_rdata = `DCT_BUSV_ENTRIES;
            {`DCT_IDX_BUSV, `DCT_SUB_1}:
                next_rdata = {31'h00000000, busv_flag};
            {`DCT_IDX_BUSV, `DCT_SUB_2}: next_rdata = {16'h0000, busv_val};
            {`DCT_IDX_CTEST, `DCT_SUB_0}: next_rdata = `DCT_CTEST_ENTRIES;
            {`DCT_IDX_CTEST, `DCT_SUB_1}:
                next_rdata = {24'h000000, ctest_duration};
            {`DCT_IDX_CTEST, `DCT_SUB_2}: next_rdata = {16'h0000, ctest_amp_q};
            {`DCT_IDX_CTEST, `DCT_SUB_3}: next_rdata = {16'h0000, ctest_amp_d};
            {`DCT_IDX_MTEST, `DCT_SUB_0}: next_rdata = `DCT_MTEST_ENTRIES;
            {`DCT_IDX_MTEST, `DCT_SUB_1}:
                next_rdata = {16'h0000, mtest_duration};
            {`DCT_IDX_MTEST, `DCT_SUB_2}: next_rdata = vel_entry;
            {`DCT_IDX_MTEST, `DCT_SUB_3}: next_rdata = mtest_accel;
            {`DCT_IDX_MTEST, `DCT_SUB_4}: next_rdata = travel_limit;
            {`DCT_IDX_TEST, `DCT_SUB_0}: next_rdata = `DCT_TEST_ENTRIES;
            {`DCT_IDX_TEST, `DCT_SUB_1}: next_rdata = {24'h000000, test_sel};
            {`DCT_IDX_TEST, `DCT_SUB_3}:
                next_rdata = {24'h000000, test_status};
            default: next_err = 1'b1;
        endcase
        // Writable entries; every other mapped entry is read-only
        case (key)
            {`DCT_IDX_CALIB, `DCT_SUB_1}, {`DCT_IDX_CALIB, `DCT_SUB_2},
            {`DCT_IDX_CALIB, `DCT_SUB_3}, {`DCT_IDX_CALIB, `DCT_SUB_4},
            {`DCT_IDX_CALIB, `DCT_SUB_5}, {`DCT_IDX_CTEST, `DCT_SUB_1},
            {`DCT_IDX_CTEST, `DCT_SUB_2}, {`DCT_IDX_CTEST, `DCT_SUB_3},
            {`DCT_IDX_MTEST, `DCT_SUB_1}, {`DCT_IDX_MTEST, `DCT_SUB_2},
            {`DCT_IDX_MTEST, `DCT_SUB_3}, {`DCT_IDX_MTEST, `DCT_SUB_4},
            {`DCT_IDX_TEST, `DCT_SUB_1}, {`DCT_IDX_TEST, `DCT_SUB_2}:
                rw_hit = 1'b1;
            default: ro_hit = !next_err;
        endcase
        // Write-only entries abort reads; read-only entries abort writes
        if (od_wr && ro_hit)
            next_err = 1'b1;
        if (od_rd && (key == {`DCT_IDX_CALIB, `DCT_SUB_1} ||
                      key == {`DCT_IDX_TEST, `DCT_SUB_2}))
            next_err = 1'b1;
        if (od_wr && key == {`DCT_IDX_TEST, `DCT_SUB_1} &&
            od_wdata[7:0] > `DCT_SEL_LAST)
            next_err = 1'b1;
    end

    assign wr_ok = od_wr && rw_hit && !next_err;
    assign cal_go = wr_ok && key == {`DCT_IDX_CALIB, `DCT_SUB_1} &&
                    od_wdata[7:0] != 8'h00;
    assign launch = wr_ok && key == {`DCT_IDX_TEST, `DCT_SUB_2} &&
                    od_wdata[7:0] == `DCT_LAUNCH_CODE;

    // Access answer, one cycle after the request
    always @(posedge clk) begin
        if (!rst_n) begin
            od_ack <= 1'b0;
            od_err <= 1'b0;
            od_rdata <= 32'h00000000;
        end else begin
            od_ack <= od_wr | od_rd;
            od_err <= (od_wr | od_rd) & next_err;
            od_rdata <= (od_rd && !next_err) ? next_rdata : 32'h00000000;
        end
    end

    // Writable configuration entries
    always @(posedge clk) begin
        if (!rst_n) begin
            ref_offset <= 16'h0000;
            dead_band <= 16'h0000;
            ctest_duration <= `DCT_RST_CTEST_DUR;
            ctest_amp_q <= `DCT_RST_CTEST_AMP;
            ctest_amp_d <= `DCT_RST_CTEST_AMP;
            mtest_duration <= `DCT_RST_MTEST_DUR;
            vel_entry <= `DCT_RST_MTEST_VEL;
            mtest_accel <= `DCT_RST_MTEST_ACC;
            travel_limit <= `DCT_RST_MTEST_LEN;
            test_sel <= `DCT_SEL_NORMAL;
        end else if (wr_ok) begin
            case (key)
                {`DCT_IDX_CALIB, `DCT_SUB_4}: ref_offset <= od_wdata[15:0];
                {`DCT_IDX_CALIB, `DCT_SUB_5}: dead_band <= od_wdata[15:0];
                {`DCT_IDX_CTEST, `DCT_SUB_1}: ctest_duration <= od_wdata[7:0];
                {`DCT_IDX_CTEST, `DCT_SUB_2}: ctest_amp_q <= od_wdata[15:0];
                {`DCT_IDX_CTEST, `DCT_SUB_3}: ctest_amp_d <= od_wdata[15:0];
                {`DCT_IDX_MTEST, `DCT_SUB_1}: mtest_duration <= od_wdata[15:0];
                {`DCT_IDX_MTEST, `DCT_SUB_2}: vel_entry <= od_wdata;
                {`DCT_IDX_MTEST, `DCT_SUB_3}: mtest_accel <= od_wdata;
                {`DCT_IDX_MTEST, `DCT_SUB_4}: travel_limit <= od_wdata;
                {`DCT_IDX_TEST, `DCT_SUB_1}: test_sel <= od_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Offset calibration: the sum of 32 samples is the mean times 32
    // master calibrates only when the drive is switched on
    always @(posedge clk) begin
        if (!rst_n) begin
            cal_state <= ST_IDLE;
            cal_count <= 6'h00;
            calib_busy <= 1'b0;
            // Sums are cleared at each trigger, so no reset is needed
            phase_v_offset <= 16'h0000;
            phase_w_offset <= 16'h0000;
            mon_u <= 16'h0000;
            mon_v <= 16'h0000;
            mon_w <= 16'h0000;
        end else begin
            case (cal_state)
                ST_IDLE: begin
                    if (wr_ok && key == {`DCT_IDX_CALIB, `DCT_SUB_2})
                        phase_v_offset <= od_wdata[15:0];
                    if (wr_ok && key == {`DCT_IDX_CALIB, `DCT_SUB_3})
                        phase_w_offset <= od_wdata[15:0];
                    if (cal_go) begin
                        cal_state <= ST_ACC;
                        calib_busy <= 1'b1;
                        cal_count <= 6'h00;
                        acc_u <= 16'h0000;
                        acc_v <= 16'h0000;
                        acc_w <= 16'h0000;
                    end
                end
                ST_ACC: begin
                    if (adc_valid) begin
                        acc_u <= acc_u + sx11(adc_u);
                        acc_v <= acc_v + sx11(adc_v);
                        acc_w <= acc_w + sx11(adc_w);
                        cal_count <= cal_count + 6'h01;
                    end
                    if (cal_count == `DCT_CAL_SAMPLES) begin
                        cal_state <= ST_IDLE;
                        calib_busy <= 1'b0;
                        phase_v_offset <= acc_v;
                        phase_w_offset <= acc_w;
                        mon_u <= acc_u;
                        mon_v <= acc_v;
                        mon_w <= acc_w;
                    end
                end
                default: cal_state <= ST_IDLE;
            endcase
        end
    end

    assign ref_scaled = {adc_ref, 5'h00};
    assign ref_diff = {ref_scaled[15], ref_scaled} -
                      {ref_offset[15], ref_offset};
    assign ref_clamped = clamp(ref_diff[16:5]);

    // Target value, measurements and bus voltage sampling
    always @(posedge clk) begin
        if (!rst_n) begin
            target_value <= 16'h0000;
            iq_val <= 16'h0000;
            id_val <= 16'h0000;
            iu_val <= 16'h0000;
            iv_val <= 16'h0000;
            iw_val <= 16'h0000;
            busv_val <= 16'h0000;
            busv_flag <= 1'b0;
        end else begin
            if (adc_valid) begin
                if (!dead_band[15] &&
                    ($signed(ref_clamped) <= $signed(dead_band)) &&
                    ($signed(ref_clamped) >= -$signed(dead_band))) begin
                    target_value <= 16'h0000;
                end else begin
                    target_value <= ref_clamped;
                end
            end
            iq_val <= cur_q;
            id_val <= cur_d;
            iu_val <= cur_u;
            iv_val <= cur_v;
            iw_val <= cur_w;
            busv_flag <= (LARGE_VARIANT == 0) &&
                         (bus_voltage > `DCT_BUS_30V_CODE);
            busv_val <= (LARGE_VARIANT != 0) ? bus_voltage : 16'h0000;
        end
    end

    // Test launch, progress and mode driven to the core
    always @(posedge clk) begin
        if (!rst_n) begin
            test_active <= 1'b0;
            test_mode <= 4'h0;
            test_status <= `DCT_TST_IDLE;
        end else if (launch) begin
            test_mode <= sel_mode(test_sel);
            test_active <= test_sel != `DCT_SEL_NORMAL;
            test_status <= (test_sel != `DCT_SEL_NORMAL) ?
                           `DCT_TST_RUN : `DCT_TST_IDLE;
        end else if (test_active && test_done) begin
            test_active <= 1'b0;
            test_mode <= 4'h0;
            test_status <= `DCT_TST_DONE;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            mtest_velocity <= `DCT_RST_MTEST_VEL;
            mtest_path_limit <= `DCT_RST_MTEST_LEN;
        end else if (test_sel == `DCT_SEL_MAX_VEL) begin
            mtest_velocity <= 32'h00000000;
            mtest_path_limit <= vel_entry;
        end else begin
            mtest_velocity <= vel_entry;
            mtest_path_limit <= travel_limit;
        end
    end

endmodule

// ==== tb/dct_master.sv ====
/*
 * Fieldbus master model: issues one object access at a time.
 * Assumes the answer comes exactly one cycle after each request.
 */
`timescale 1ns/1ps
module dct_master (
    input wire clk,
    output reg [15:0] od_index,
    output reg [7:0] od_sub,
    output reg od_wr,
    output reg od_rd,
    output reg [31:0] od_wdata,
    input wire [31:0] od_rdata,
    input wire od_ack,
    input wire od_err
);
    // Idle bus carries no request
    initial begin
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = 16'h0000;
        od_sub = 8'h00;
        od_wdata = 32'h00000000;
    end
    // Request pulses one cycle; the answer is taken a cycle later
    task xfer(input bit wr, input [15:0] idx, input [7:0] sub,
            input [31:0] wd, output [31:0] rd, output logic err,
            output logic ok);
        @(negedge clk);
        od_index = idx;
        od_sub = sub;
        od_wdata = wd;
        od_wr = wr;
        od_rd = !wr;
        @(negedge clk);
        od_wr = 1'b0;
        od_rd = 1'b0;
        ok = od_ack;
        rd = od_rdata;
        err = od_err;
        // Stale data is not left on the bus
        od_wdata = ~wd;
        od_index = ~idx;
    endtask
endmodule

// ==== tb/dct_top_properties.sv ====
/*
 * Port-level properties of the calibration and test objects.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module dct_top_properties (
    input wire clk,
    input wire rst_n,
    input wire [15:0] od_index,
    input wire [7:0] od_sub,
    input wire od_wr,
    input wire od_rd,
    input wire [31:0] od_wdata,
    input wire od_ack,
    input wire od_err,
    input wire adc_valid,
    input wire calib_busy,
    input wire [15:0] phase_v_offset,
    input wire [15:0] target_value,
    input wire test_active,
    input wire [3:0] test_mode,
    input wire [31:0] mtest_velocity
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decoded accesses
    wire wr_cal = od_wr && od_index == 16'h2064 && od_sub == 8'h01;
    wire wr_ofs = od_wr && od_index == 16'h2064 && od_sub == 8'h02;
    wire wr_sel = od_wr && od_index == 16'h20a0 && od_sub == 8'h01;
    wire launch = od_wr && od_index == 16'h20a0 && od_sub == 8'h02 &&
        od_wdata[7:0] == 8'h01;
    reg [7:0] sel;
    reg [5:0] cnt;
    // Shadow of the accepted selection; out-of-range writes are refused
    always @(posedge clk) begin
        if (!rst_n)
            sel <= 8'h00;
        else if (wr_sel && od_wdata[7:0] <= 8'h0a)
            sel <= od_wdata[7:0];
    end
    // Samples taken during one calibration run
    always @(posedge clk) begin
        if (!rst_n || !calib_busy)
            cnt <= 6'h00;
        else if (adc_valid)
            cnt <= cnt + 6'h01;
    end
    AST_ACK_NEXT: assert property ((od_wr || od_rd) |=> od_ack)
        else $error("request without answer");
    AST_ACK_CAUSE: assert property (od_ack |-> $past(od_wr || od_rd))
        else $error("answer without request");
    AST_ERR_ACK: assert property (od_err |-> od_ack)
        else $error("abort outside answer");
    AST_CUR_RO: assert property (
        od_wr && od_index == 16'h2070 |=> od_err)
        else $error("current write accepted");
    AST_SEL_RANGE: assert property (
        wr_sel && od_wdata[7:0] > 8'h0a |=> od_err)
        else $error("bad selection accepted");
    AST_CAL_GO: assert property (
        wr_cal && od_wdata[7:0] != 8'h00 && !calib_busy |=> calib_busy)
        else $error("calibration not started");
    AST_CAL_NO: assert property (
        wr_cal && od_wdata[7:0] == 8'h00 && !calib_busy |=> !calib_busy)
        else $error("zero trigger started calibration");
    AST_CAL_LEN: assert property (calib_busy |-> cnt <= 6'h20)
        else $error("calibration overran");
    AST_CAL_END: assert property (
        calib_busy && cnt == 6'h20 |=> !calib_busy)
        else $error("calibration did not end");
    AST_OFS_WR: assert property (
        wr_ofs && !calib_busy |=> phase_v_offset == $past(od_wdata[15:0]))
        else $error("offset write lost");
    AST_TGT_RANGE: assert property (
        $signed(target_value) <= 1023 && $signed(target_value) >= -1023)
        else $error("target out of range");
    AST_LAUNCH: assert property (
        launch && sel != 8'h00 |=> test_active && test_mode == sel[3:0])
        else $error("launch failed");
    AST_STOP: assert property (
        launch && sel == 8'h00 |=> !test_active && test_mode == 4'h0)
        else $error("normal mode not restored");
    AST_VEL6: assert property (
        $stable(sel) && sel == 8'h06 |-> mtest_velocity == 32'h00000000)
        else $error("velocity used in selection 6");
    COV_CAL: cover property (calib_busy ##1 !calib_busy);
    COV_RUN: cover property (launch && sel == 8'h0a);
    COV_ERR: cover property (od_err);
endmodule
bind dct_top dct_top_properties i_props (.clk, .rst_n, .od_index,
    .od_sub, .od_wr, .od_rd, .od_wdata, .od_ack, .od_err, .adc_valid,
    .calib_busy, .phase_v_offset, .target_value, .test_active,
    .test_mode, .mtest_velocity);

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the calibration and test-signal objects.
 * Assumes the small variant and a master model on the object port.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    tests_run = tests_run + 1; \
    if ((g) !== (e)) begin \
        failures = failures + 1; \
        $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
end
module testbench;
    reg clk, rst_n, adc_valid, test_done;
    reg [10:0] adc_u, adc_v, adc_w, adc_ref;
    reg [15:0] cur_q, cur_d, cur_u, cur_v, cur_w, bus_voltage;
    wire [15:0] od_index, phase_v_offset, phase_w_offset, target_value;
    wire [7:0] od_sub, ctest_duration;
    wire od_wr, od_rd, od_ack, od_err, calib_busy, test_active;
    wire [31:0] od_wdata, od_rdata, mtest_velocity, mtest_path_limit;
    wire [3:0] test_mode;
    integer failures, tests_run, seed, i, m, su, sv, sw;
    reg [31:0] rd, vel;
    logic er, ok;
    dct_top i_dut (.clk, .rst_n, .od_index, .od_sub, .od_wr, .od_rd,
        .od_wdata, .od_rdata, .od_ack, .od_err, .adc_valid, .adc_u,
        .adc_v, .adc_w, .adc_ref, .cur_q, .cur_d, .cur_u, .cur_v, .cur_w,
        .bus_voltage, .test_done, .calib_busy, .phase_v_offset,
        .phase_w_offset, .target_value, .test_active, .test_mode,
        .ctest_duration, .ctest_amp_q(), .ctest_amp_d(),
        .mtest_duration(), .mtest_velocity, .mtest_accel(),
        .mtest_path_limit);
    dct_master i_master (.clk, .od_index, .od_sub, .od_wr, .od_rd,
        .od_wdata, .od_rdata, .od_ack, .od_err);
    function [31:0] sx(input [15:0] x);
        sx = {{16{x[15]}}, x};
    endfunction
    task end_sim;
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // A missing answer stops the run at once
    task acc(input bit wr, input [15:0] idx, input [7:0] sub,
            input [31:0] wd);
        i_master.xfer(wr, idx, sub, wd, rd, er, ok);
        if (ok !== 1'b1) begin
            failures = failures + 1;
            end_sim;
        end
    endtask
    task rchk(input [15:0] idx, input [7:0] sub, input [31:0] e);
        acc(1'b0, idx, sub, 32'h0);
        `CHK("read data", e, rd)
        `CHK("read abort", 1'b0, er)
    endtask
    task echk(input bit wr, input [15:0] idx, input [7:0] sub,
            input [31:0] wd);
        acc(wr, idx, sub, wd);
        `CHK("abort", 1'b1, er)
    endtask
    task strobe;
        @(negedge clk) adc_valid = 1'b1;
        @(negedge clk) adc_valid = 1'b0;
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {adc_valid, test_done, adc_u, adc_v, adc_w, adc_ref} = 0;
        {cur_q, cur_d, cur_u, cur_v, cur_w, bus_voltage} = 0;
        failures = 0;
        tests_run = 0;
        seed = 32'h6ff5dcbf;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        // Defaults of the test parameters
        `CHK("ct duration", 8'h19, ctest_duration)
        rchk(16'h2090, 8'h02, 32'h64);
        rchk(16'h2090, 8'h03, 32'h64);
        rchk(16'h2091, 8'h01, 32'h1f4);
        rchk(16'h2091, 8'h02, 32'h2710);
        rchk(16'h2091, 8'h03, 32'hf4240);
        rchk(16'h2091, 8'h04, 32'hc350);
        // Refused accesses
        echk(1'b1, 16'h2070, 8'h01, 32'h1);
        echk(1'b0, 16'h2064, 8'h01, 32'h0);
        echk(1'b1, 16'h2071, 8'h00, 32'h0);
        echk(1'b1, 16'h2072, 8'h01, 32'h1);
        echk(1'b1, 16'h20a0, 8'h01, 32'hb);
        echk(1'b0, 16'h20a0, 8'h02, 32'h0);
        // Motor currents, sign-extended
        {cur_q, cur_d, cur_u, cur_v, cur_w} = {$random(seed),
            $random(seed), $random(seed)};
        rchk(16'h2070, 8'h01, sx(cur_q));
        rchk(16'h2070, 8'h02, sx(cur_d));
        rchk(16'h2070, 8'h03, sx(cur_u));
        rchk(16'h2070, 8'h04, sx(cur_v));
        rchk(16'h2070, 8'h05, sx(cur_w));
        // Bus level on either side of 30 V; no voltage on small variant
        bus_voltage = 16'h001f;
        rchk(16'h2072, 8'h01, 32'h1);
        bus_voltage = 16'h001d;
        rchk(16'h2072, 8'h01, 32'h0);
        rchk(16'h2072, 8'h02, 32'h0);
        // Direct offset writes
        vel = $random(seed);
        acc(1'b1, 16'h2064, 8'h03, vel);
        rchk(16'h2064, 8'h03, sx(vel[15:0]));
        `CHK("offset w", vel[15:0], phase_w_offset)
        // Reference offset 2 counts, dead band 3; small values hit it
        acc(1'b1, 16'h2064, 8'h04, 32'd64);
        acc(1'b1, 16'h2064, 8'h05, 32'd3);
        for (i = 0; i < 24; i = i + 1) begin
            m = i[0] ? $random(seed) : $random(seed) % 6;
            adc_ref = m[10:0];
            strobe;
            m = $signed(adc_ref);
            m = (m * 32 - 64) >>> 5;
            m = m > 1023 ? 1023 : (m < -1023 ? -1023 : m);
            m = (m <= 3 && m >= -3) ? 0 : m;
            `CHK("target", m[15:0], target_value)
        end
        rchk(16'h2071, 8'h00, m);
        // Zero trigger is ignored, nonzero starts a 32-sample run
        acc(1'b1, 16'h2064, 8'h01, 32'h0);
        `CHK("busy", 1'b0, calib_busy)
        // drive taken as switched on here
        acc(1'b1, 16'h2064, 8'h01, 32'h5a);
        `CHK("busy", 1'b1, calib_busy)
        {su, sv, sw} = 0;
        for (i = 0; i < 32; i = i + 1) begin
            {adc_u, adc_v, adc_w} = $random(seed);
            su = su + $signed(adc_u);
            sv = sv + $signed(adc_v);
            sw = sw + $signed(adc_w);
            strobe;
        end
        for (i = 0; i < 4 && calib_busy !== 1'b0; i = i + 1)
            @(negedge clk);
        `CHK("busy", 1'b0, calib_busy)
        `CHK("offset v", sv[15:0], phase_v_offset)
        `CHK("offset w", sw[15:0], phase_w_offset)
        rchk(16'h2064, 8'h06, sx(su[15:0]));
        // Every selection launched; selections 1 to 10 then ended by the core
        vel = $random(seed);
        acc(1'b1, 16'h2091, 8'h02, vel);
        for (i = 0; i <= 10; i = i + 1) begin
            acc(1'b1, 16'h20a0, 8'h01, i);
            acc(1'b1, 16'h20a0, 8'h02, 32'h1);
            `CHK("mode", i[3:0], test_mode)
            `CHK("active", i != 0, test_active)
            rchk(16'h20a0, 8'h03, i != 0);
            if (i == 6) begin
                `CHK("velocity", 32'h0, mtest_velocity)
                `CHK("path", vel, mtest_path_limit)
            end
            if (i == 7)
                `CHK("velocity", vel, mtest_velocity)
            @(negedge clk) test_done = 1'b1;
            @(negedge clk) test_done = 1'b0;
            rchk(16'h20a0, 8'h03, i != 0 ? 32'h2 : 32'h0);
            `CHK("active", 1'b0, test_active)
        end
        end_sim;
    end
endmodule
